// ---- rcsd_pkg.sv ----
package rcsd_pkg;
  // Address field and frame layout
  localparam int ADDR_W = 6;
  localparam int HDR_RAM_BIT = 7; // Header bit selecting RAM access
  localparam int HDR_READ_BIT = 6; // Header bit selecting a read
  localparam logic [4:0] ADDR_BITS_LAST = 5'h07;
  localparam logic [4:0] WORD_BITS_LAST = 5'h0F;
  localparam logic [4:0] BYTE_BITS_LAST = 5'h07;
  localparam logic [4:0] BIT_CNT_RESET = 5'h00;
  // Strobe addresses
  localparam logic [5:0] STROBE_NO_OPERATION = 6'h00;
  localparam logic [5:0] STROBE_OSCILLATOR_ON = 6'h01;
  localparam logic [5:0] STROBE_SYNTH_CALIBRATE = 6'h02;
  localparam logic [5:0] STROBE_RECEIVE_ON = 6'h03;
  localparam logic [5:0] STROBE_TRANSMIT_ON = 6'h04;
  localparam logic [5:0] STROBE_TRANSMIT_IF_CLEAR = 6'h05;
  localparam logic [5:0] STROBE_RADIO_OFF = 6'h06;
  localparam logic [5:0] STROBE_OSCILLATOR_OFF = 6'h07;
  localparam logic [5:0] STROBE_FLUSH_RECEIVE = 6'h08;
  localparam logic [5:0] STROBE_FLUSH_TRANSMIT = 6'h09;
  localparam logic [5:0] STROBE_SEND_ACK = 6'h0A;
  localparam logic [5:0] STROBE_SEND_ACK_PENDING = 6'h0B;
  localparam logic [5:0] STROBE_RECEIVE_DECRYPT = 6'h0C;
  localparam logic [5:0] STROBE_TRANSMIT_ENCRYPT = 6'h0D;
  localparam logic [5:0] STROBE_LAST = 6'h0E; // Fifteen strobe codes, 0x00 to 0x0E
  // Ordinary registers and byte queues
  localparam logic [5:0] REG_FIRST = 6'h10; // Main control register
  localparam int REG_COUNT = 33;
  localparam logic [5:0] REG_LAST = 6'h30;
  localparam logic [5:0] REG_SECURITY = 6'h19; // Holds the serial security mode
  localparam logic [5:0] REG_FSM_STATE = 6'h2C; // Read-only radio state
  localparam logic [5:0] ADDR_TX_QUEUE = 6'h3E;
  localparam logic [5:0] ADDR_RX_QUEUE = 6'h3F;
  // Fields and reset values
  localparam int MAIN_SOFT_RESET_BIT = 15;
  localparam int MAIN_OSC_PD_BIT = 0;
  localparam int MAIN_BIAS_POWER_DOWN_BIT = 1;
  localparam int SEC_MODE_LSB = 0;
  localparam int SEC_MODE_W = 2;
  localparam logic [15:0] MAIN_RESET = 16'h8003;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // Status byte bit positions
  localparam int ST_OSC_BIT = 6;
  localparam int ST_CAL_BIT = 4;
  localparam int ST_TX_BIT = 3;
  localparam int ST_RX_BIT = 1;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Crossing depth of pin and toggle synchronisers
  localparam int SYNC_STAGES = 3;
  // Event kinds posted from the serial side
  typedef enum logic [1:0] {
    EV_STROBE = 2'b00,
    EV_WRITE = 2'b01,
    EV_TX_BYTE = 2'b11,
    EV_RX_POP = 2'b10
  } rcsd_event_e;
  // Radio state, Gray coded along off-idle-rx-tx-synth
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_IDLE = 3'b001,
    ST_RX = 3'b011,
    ST_TX = 3'b010,
    ST_SYNTH = 3'b110
  } rcsd_radio_e;
endpackage

// ---- rcsd_top.sv ----
// Contract
// RULE1: Configuration registers are sixteen bits, serially reachable.
// RULE2: Pin or soft reset loads register defaults.
// RULE3: Main control register resets only on pin.
// RULE4: Main write stores all bits; soft reset low-high.
// RULE5: Fifteen strobe addresses trigger actions, store nothing.
// RULE6: Thirty-three ordinary sixteen-bit registers exist.
// RULE7: Two byte queue registers; transmit one write-only.
// RULE8: RAM reads of transmit data do not pop.
// RULE9: Host starts oscillator before queue or RAM access.
// RULE10: Status byte driven during address and transmit writes.
// RULE11: Strobe 0x00 only returns status.
// RULE12: Strobe 0x01 clears oscillator and bias power-down.
// RULE13: Strobe 0x02 calibrates synth, waits synth-only.
// RULE14: Strobe 0x03 receives; 0x06 disables radio.
// RULE15: Strobe 0x04 transmits, calibrates, maybe encrypts.
// RULE16: Strobe 0x05 transmits only on clear channel.
// RULE17: Strobe 0x07 turns oscillator and radio off.
// RULE18: Strobe 0x08 flushes receive, resets demodulator.
// RULE19: Strobe 0x09 flushes transmit queue.
// RULE20: Strobes 0x0A/0x0B send ack, pending clear/set.
// RULE21: Strobe 0x0C starts receive decryption.
// RULE22: Strobe 0x0D starts encryption without transmitting.
`timescale 1ns/1ps
`default_nettype none
module rcsd_top (
  input wire logic clk, // System clock, 20 MHz
  input wire logic rst_n, // Pin reset, synchronous
  input wire logic sclk, // Serial clock from host
  input wire logic csn_n, // Serial frame select
  input wire logic si, // Serial data in
  input wire logic cca_clear, // Clear channel indication
  input wire logic [7:0] rx_byte, // Head of receive queue
  input wire logic [7:0] ram_rdata, // RAM byte at ram_addr
  output logic so, // Serial data out
  output logic so_oe, // Serial output enable
  output logic osc_enable, // Crystal oscillator on
  output logic bias_enable, // Bias on
  output logic [2:0] radio_state, // Current radio state
  output logic [1:0] security_mode, // Serial security mode
  output logic cal_start, // Synthesizer calibration pulse
  output logic rx_flush, // Receive flush and demod reset pulse
  output logic tx_flush, // Transmit flush pulse
  output logic ack_send, // Acknowledge frame pulse
  output logic ack_pending, // Pending field of that frame
  output logic decrypt_start, // Receive decryption pulse
  output logic encrypt_start, // Transmit encryption pulse
  output logic tx_byte_valid, // Transmit byte pulse
  output logic [7:0] tx_byte, // Transmit byte
  output logic rx_pop, // Receive byte consumed pulse
  output logic [7:0] ram_addr // RAM byte address
);

  // ---------------- Serial side, on sclk ----------------
  logic [15:0] sh; // Input shift register
  logic [4:0] bit_cnt; // Bit position in current field
  logic addr_done; // Header byte received
  logic [7:0] hdr; // Captured header
  logic ram_addr_done; // RAM address byte received
  logic [15:0] rd_word; // Register word captured for read
  // Event mailbox; kept across frames, not cleared by csn
  rcsd_pkg::rcsd_event_e ev_kind = rcsd_pkg::EV_STROBE;
  logic [5:0] ev_addr = 6'h00;
  logic [15:0] ev_data = 16'h0000;
  logic ev_tgl = 1'b0;

  // Clock-side state read by serial side
  logic [7:0] status; // Status byte
  logic [15:0] cfg [rcsd_pkg::REG_COUNT]; // Ordinary registers
  rcsd_pkg::rcsd_radio_e state; // Radio state

  // Register read decode, used for capture on sclk
  function automatic logic [15:0] reg_read(input logic [5:0] a);
    logic [5:0] idx;
    idx = 6'(a - rcsd_pkg::REG_FIRST);
    if (a == rcsd_pkg::REG_FSM_STATE) begin
      reg_read = {13'h0000, state};
    end else if (a >= rcsd_pkg::REG_FIRST && a <= rcsd_pkg::REG_LAST) begin
      reg_read = cfg[idx];
    end else begin
      reg_read = 16'h0000;
    end
  endfunction

  // Header decode
  wire [7:0] hdr_in = {sh[6:0], si};
  wire [5:0] hdr_in_addr = hdr_in[5:0];
  wire hdr_in_strobe = !hdr_in[rcsd_pkg::HDR_RAM_BIT] && hdr_in_addr <= rcsd_pkg::STROBE_LAST;
  wire is_ram = hdr[rcsd_pkg::HDR_RAM_BIT];
  wire is_read = hdr[rcsd_pkg::HDR_READ_BIT];
  wire [5:0] cur_addr = hdr[5:0];
  wire is_word = !is_ram && cur_addr >= rcsd_pkg::REG_FIRST && cur_addr <= rcsd_pkg::REG_LAST;
  wire is_txq = !is_ram && cur_addr == rcsd_pkg::ADDR_TX_QUEUE;
  wire is_rxq = !is_ram && cur_addr == rcsd_pkg::ADDR_RX_QUEUE;
  wire field_last = is_word ? (bit_cnt == rcsd_pkg::WORD_BITS_LAST)
                            : (bit_cnt == rcsd_pkg::BYTE_BITS_LAST);
  wire word_done = addr_done && is_word && field_last;
  wire byte_done = addr_done && !is_word && field_last;
  wire [4:0] next_bit_cnt = field_last ? rcsd_pkg::BIT_CNT_RESET : 5'(bit_cnt + 5'h01);

  // Frame framing; csn high clears the field state
  always_ff @(posedge sclk or posedge csn_n) begin
    if (csn_n) begin
      sh <= 16'h0000;
      bit_cnt <= rcsd_pkg::BIT_CNT_RESET;
      addr_done <= 1'b0;
      hdr <= 8'h00;
      ram_addr_done <= 1'b0;
      rd_word <= 16'h0000;
      ram_addr <= 8'h00;
    end else begin
      sh <= {sh[14:0], si};
      // Counter wraps at the end of every field
      bit_cnt <= next_bit_cnt;
      // Header complete: capture address and read word
      if (!addr_done && bit_cnt == rcsd_pkg::ADDR_BITS_LAST) begin
        addr_done <= 1'b1;
        hdr <= hdr_in;
        rd_word <= reg_read(hdr_in_addr); // RULE1
      end
      // First byte after a RAM header is the RAM address
      if (byte_done && is_ram && !ram_addr_done) begin
        ram_addr_done <= 1'b1;
        ram_addr <= hdr_in;
      end
    end
  end

  // Post events to the clock side by toggle
  always_ff @(posedge sclk) begin
    if (!csn_n && !addr_done && bit_cnt == rcsd_pkg::ADDR_BITS_LAST && hdr_in_strobe) begin
      // Strobes act on address alone, nothing stored
      ev_kind <= rcsd_pkg::EV_STROBE; // RULE5
      ev_addr <= hdr_in_addr;
      ev_tgl <= !ev_tgl;
    end else if (!csn_n && word_done && !is_read) begin
      // Whole word written to a register
      ev_kind <= rcsd_pkg::EV_WRITE; // RULE4
      ev_addr <= cur_addr;
      ev_data <= {sh[14:0], si};
      ev_tgl <= !ev_tgl;
    end else if (!csn_n && byte_done && is_txq && !is_read) begin
      // Transmit queue takes writes only
      ev_kind <= rcsd_pkg::EV_TX_BYTE; // RULE7
      ev_addr <= cur_addr;
      ev_data <= {8'h00, hdr_in};
      ev_tgl <= !ev_tgl;
    end else if (!csn_n && byte_done && is_rxq && is_read) begin
      // Receive byte read out, pop it
      ev_kind <= rcsd_pkg::EV_RX_POP; // RULE7
      ev_addr <= cur_addr;
      ev_tgl <= !ev_tgl;
    end
  end

  // Serial output bit selection
  wire [7:0] out_byte = is_ram ? ram_rdata : rx_byte; // RULE8
  wire so_status = !addr_done || (is_txq && !is_read); // RULE10
  wire next_so = so_status ? status[~bit_cnt[2:0]] :
                 is_word ? rd_word[~bit_cnt[3:0]] :
                 (is_rxq || (is_ram && ram_addr_done)) ? out_byte[~bit_cnt[2:0]] : 1'b0;

  // Output changes on falling sclk; status MSB is always zero
  always_ff @(negedge sclk or posedge csn_n) begin
    if (csn_n) begin
      so <= 1'b0;
    end else begin
      so <= next_so; // RULE10
    end
  end

  // ---------------- Clock side, on clk ----------------
  // Known start value, so the first toggle compare is clean
  logic [rcsd_pkg::SYNC_STAGES-1:0] ev_sync = '0; // Event toggle synchroniser
  logic [rcsd_pkg::SYNC_STAGES-1:0] csn_sync; // Frame select synchroniser
  logic [rcsd_pkg::SYNC_STAGES-1:0] cca_sync; // Clear channel synchroniser
  logic ev_seen; // Last accepted toggle level
  logic csn_level; // Filtered frame select
  logic cca_level; // Filtered clear channel
  logic calibrated; // Synthesizer calibration done

  // Three-stage capture of foreign signals
  always_ff @(posedge clk) begin
    ev_sync <= {ev_sync[rcsd_pkg::SYNC_STAGES-2:0], ev_tgl};
    csn_sync <= {csn_sync[rcsd_pkg::SYNC_STAGES-2:0], csn_n};
    cca_sync <= {cca_sync[rcsd_pkg::SYNC_STAGES-2:0], cca_clear};
  end

  // Stages two and three must agree before a change counts
  wire ev_agree = ev_sync[1] == ev_sync[2];
  wire ev_fire = ev_agree && ev_sync[2] != ev_seen;

  // Filtered levels and accepted toggle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ev_seen <= ev_sync[2];
      csn_level <= 1'b1;
      cca_level <= 1'b0;
    end else begin
      if (ev_agree) begin
        ev_seen <= ev_sync[2];
      end
      if (csn_sync[1] == csn_sync[2]) begin
        csn_level <= csn_sync[2];
      end
      if (cca_sync[1] == cca_sync[2]) begin
        cca_level <= cca_sync[2];
      end
    end
  end

  // Event decode
  wire fire_strobe = ev_fire && ev_kind == rcsd_pkg::EV_STROBE;
  wire fire_write = ev_fire && ev_kind == rcsd_pkg::EV_WRITE;

  // Fired flag and address travel as an argument, so that
  // continuous decodes re-evaluate on every event
  wire [6:0] ev_strobe = {fire_strobe, ev_addr};

  // Strobe match, used for every command
  function automatic logic strobe_hit(input logic [6:0] ev, input logic [5:0] code);
    strobe_hit = ev[6] && ev[5:0] == code;
  endfunction

  // Main control and soft reset
  wire [15:0] main_reg = cfg[0];
  wire soft_reset = !main_reg[rcsd_pkg::MAIN_SOFT_RESET_BIT];
  wire osc_on = !main_reg[rcsd_pkg::MAIN_OSC_PD_BIT] && !main_reg[rcsd_pkg::MAIN_BIAS_POWER_DOWN_BIT];
  wire [1:0] sec_mode = cfg[rcsd_pkg::REG_SECURITY - rcsd_pkg::REG_FIRST][
    rcsd_pkg::SEC_MODE_LSB +: rcsd_pkg::SEC_MODE_W];
  wire sec_on = sec_mode != 2'b00;
  wire main_hit = fire_write && ev_addr == rcsd_pkg::REG_FIRST;

  // Main control register: pin reset only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg[0] <= rcsd_pkg::MAIN_RESET; // RULE3
    end else if (main_hit) begin
      cfg[0] <= ev_data; // RULE4
    end else if (strobe_hit(ev_strobe, rcsd_pkg::STROBE_OSCILLATOR_ON)) begin
      cfg[0][rcsd_pkg::MAIN_OSC_PD_BIT] <= 1'b0; // RULE12
      cfg[0][rcsd_pkg::MAIN_BIAS_POWER_DOWN_BIT] <= 1'b0; // RULE12
    end else if (strobe_hit(ev_strobe, rcsd_pkg::STROBE_OSCILLATOR_OFF)) begin
      cfg[0][rcsd_pkg::MAIN_OSC_PD_BIT] <= 1'b1; // RULE17
      cfg[0][rcsd_pkg::MAIN_BIAS_POWER_DOWN_BIT] <= 1'b1; // RULE17
    end
  end

  // Other ordinary registers; state register is read-only
  genvar g;
  generate
    for (g = 1; g < rcsd_pkg::REG_COUNT; g++) begin : g_cfg
      localparam logic [5:0] ADDR = 6'(rcsd_pkg::REG_FIRST + g);
      wire hit = fire_write && ev_addr == ADDR && ADDR != rcsd_pkg::REG_FSM_STATE;
      // Pin or soft reset holds the defaults
      always_ff @(posedge clk) begin
        if (!rst_n || soft_reset) begin
          cfg[g] <= rcsd_pkg::CFG_RESET; // RULE2
        end else if (hit) begin
          cfg[g] <= ev_data; // RULE6
        end
      end
    end
  endgenerate

  // Strobe decode for the radio
  wire s_rx_on = strobe_hit(ev_strobe, rcsd_pkg::STROBE_RECEIVE_ON);
  wire s_tx_on = strobe_hit(ev_strobe, rcsd_pkg::STROBE_TRANSMIT_ON);
  // Busy channel turns the conditional transmit into nothing
  wire s_tx_cca = strobe_hit(ev_strobe, rcsd_pkg::STROBE_TRANSMIT_IF_CLEAR) && cca_level;
  wire s_cal = strobe_hit(ev_strobe, rcsd_pkg::STROBE_SYNTH_CALIBRATE);
  wire s_off = strobe_hit(ev_strobe, rcsd_pkg::STROBE_RADIO_OFF);
  // Transmit needs the oscillator running
  wire go_tx = osc_on && (s_tx_on || s_tx_cca);
  wire s_ack = strobe_hit(ev_strobe, rcsd_pkg::STROBE_SEND_ACK);
  wire s_ack_pend = strobe_hit(ev_strobe, rcsd_pkg::STROBE_SEND_ACK_PENDING);

  // Next radio state; oscillator off overrides every strobe
  rcsd_pkg::rcsd_radio_e next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      rcsd_pkg::ST_OFF: begin
        // Off waits for the oscillator to come up
        if (osc_on) begin
          next_state = rcsd_pkg::ST_IDLE;
        end
      end
      rcsd_pkg::ST_IDLE, rcsd_pkg::ST_RX, rcsd_pkg::ST_TX, rcsd_pkg::ST_SYNTH: begin
        if (s_off) begin
          next_state = rcsd_pkg::ST_IDLE; // RULE14
        end else if (s_cal) begin
          next_state = rcsd_pkg::ST_SYNTH; // RULE13
        end else if (go_tx) begin
          next_state = rcsd_pkg::ST_TX; // RULE15 RULE16
        end else if (s_rx_on) begin
          next_state = rcsd_pkg::ST_RX; // RULE14
        end
      end
      default: begin
        next_state = rcsd_pkg::ST_IDLE;
      end
    endcase
    if (!osc_on) begin
      next_state = rcsd_pkg::ST_OFF; // RULE17
    end
  end

  // Radio state and calibration flag
  always_ff @(posedge clk) begin
    if (!rst_n || soft_reset) begin
      state <= rcsd_pkg::ST_OFF;
      calibrated <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state == rcsd_pkg::ST_OFF || next_state == rcsd_pkg::ST_IDLE) begin
        calibrated <= 1'b0;
      end else if (next_state == rcsd_pkg::ST_TX || next_state == rcsd_pkg::ST_SYNTH) begin
        calibrated <= 1'b1;
      end
    end
  end

  // Pulse and level outputs, all registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cal_start <= 1'b0;
      rx_flush <= 1'b0;
      tx_flush <= 1'b0;
      ack_send <= 1'b0;
      ack_pending <= 1'b0;
      decrypt_start <= 1'b0;
      encrypt_start <= 1'b0;
      tx_byte_valid <= 1'b0;
      tx_byte <= 8'h00;
      rx_pop <= 1'b0;
      status <= rcsd_pkg::STATUS_RESET;
      so_oe <= 1'b0;
      osc_enable <= 1'b0;
      bias_enable <= 1'b0;
      radio_state <= rcsd_pkg::ST_OFF;
      security_mode <= 2'b00;
    end else begin
      // Calibrate on synth strobe, or before transmit if needed
      cal_start <= osc_on && (s_cal || (go_tx && !calibrated)); // RULE13 RULE15 RULE16
      // Flush pulses for both queues
      rx_flush <= strobe_hit(ev_strobe, rcsd_pkg::STROBE_FLUSH_RECEIVE); // RULE18
      tx_flush <= strobe_hit(ev_strobe, rcsd_pkg::STROBE_FLUSH_TRANSMIT); // RULE19
      ack_send <= osc_on && (s_ack || s_ack_pend); // RULE20
      // Pending field follows the latest ack strobe
      if (s_ack || s_ack_pend) begin
        ack_pending <= s_ack_pend; // RULE20
      end
      decrypt_start <= strobe_hit(ev_strobe, rcsd_pkg::STROBE_RECEIVE_DECRYPT); // RULE21
      // Encryption with transmit, or alone without transmit
      encrypt_start <= (go_tx && sec_on) ||
                       strobe_hit(ev_strobe, rcsd_pkg::STROBE_TRANSMIT_ENCRYPT); // RULE15 RULE22
      // Queue events become one-cycle pulses
      tx_byte_valid <= ev_fire && ev_kind == rcsd_pkg::EV_TX_BYTE;
      if (ev_fire && ev_kind == rcsd_pkg::EV_TX_BYTE) begin
        tx_byte <= ev_data[7:0];
      end
      rx_pop <= ev_fire && ev_kind == rcsd_pkg::EV_RX_POP;
      // No-op strobe leaves everything but status untouched
      status <= {1'b0, osc_on, 1'b0, calibrated, state == rcsd_pkg::ST_TX, 1'b0,
                 state == rcsd_pkg::ST_RX, 1'b0}; // RULE11
      // Levels follow the filtered select and main bits
      so_oe <= !csn_level;
      osc_enable <= !main_reg[rcsd_pkg::MAIN_OSC_PD_BIT];
      bias_enable <= !main_reg[rcsd_pkg::MAIN_BIAS_POWER_DOWN_BIT];
      radio_state <= next_state;
      security_mode <= sec_mode;
    end
  end

endmodule
`default_nettype wire

// ---- rcsd_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the strobe and register front end
module rcsd_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic csn_n,
  input wire logic so,
  input wire logic so_oe,
  input wire logic [2:0] radio_state,
  input wire logic [1:0] security_mode,
  input wire logic osc_enable,
  input wire logic cal_start,
  input wire logic ack_send,
  input wire logic ack_pending,
  input wire logic tx_byte_valid,
  input wire logic rx_pop
);
  // One clock domain, pin reset disables
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_reset_quiet: assert property (disable iff (1'b0)
    (!rst_n) [*2] |=> {cal_start, ack_send, osc_enable, radio_state, security_mode} == 8'h00)
    else $error("outputs not cleared by reset");
  a_cal_single: assert property (cal_start |=> !cal_start)
    else $error("calibration pulse longer than one cycle");
  a_txb_single: assert property (tx_byte_valid |=> !tx_byte_valid)
    else $error("transmit byte pulse longer than one cycle");
  a_pop_single: assert property (rx_pop |=> !rx_pop)
    else $error("receive pop longer than one cycle");
  a_so_idle: assert property (csn_n |-> !so)
    else $error("serial out not low outside a frame");
  a_oe_off: assert property (csn_n [*7] |-> !so_oe)
    else $error("serial out enabled outside a frame");
  a_oe_on: assert property ((!csn_n) [*7] |-> so_oe)
    else $error("serial out not enabled inside a frame");
  a_ack_level: assert property ($rose(ack_pending) |-> ack_send || $past(ack_send))
    else $error("pending flag rose without an acknowledge");
  a_state_legal: assert property (radio_state inside {3'b000, 3'b001, 3'b011, 3'b010, 3'b110})
    else $error("radio state outside its code set");
endmodule
`default_nettype wire

// ---- rcsd_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host end of the serial link; clock runs only inside frames
module rcsd_host (
  output logic sclk,
  output logic csn_n,
  output logic si,
  input wire logic so
);
  // Half of the 30 ns link period
  localparam int HALF = 15;
  // Select low and clock low at time zero
  initial begin
    sclk = 1'b0;
    csn_n = 1'b0;
    si = 1'b1;
    // Late rising select clears the serial framing at start
    #1;
    csn_n = 1'b1;
  end
  // Shift n bits of wd MSB first, collect serial out into rd
  task automatic frame(input logic [31:0] wd, input int n, output logic [31:0] rd);
    rd = 32'h0;
    csn_n = 1'b0;
    #HALF;
    for (int i = n - 1; i >= 0; i--) begin
      si = wd[i];
      #HALF;
      sclk = 1'b1;
      rd[i] = so;
      #HALF;
      sclk = 1'b0;
    end
    #HALF;
    csn_n = 1'b1;
    // Released data line shows no stale value
    si = ~si;
  endtask
endmodule
`default_nettype wire

// ---- test_radio_config_strobe_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
bind rcsd_top rcsd_assertions i_chk (.clk(clk), .rst_n(rst_n), .csn_n(csn_n), .so(so),
  .so_oe(so_oe), .radio_state(radio_state), .security_mode(security_mode),
  .osc_enable(osc_enable), .cal_start(cal_start), .ack_send(ack_send),
  .ack_pending(ack_pending), .tx_byte_valid(tx_byte_valid), .rx_pop(rx_pop));
module test_radio_config_strobe_decoder;
  logic clk, rst_n, cca_clear; // Clock, pin reset, channel clear
  logic [7:0] rx_byte; // Head of receive queue
  wire logic sclk, csn_n, si, so, so_oe, osc_enable, bias_enable;
  wire logic cal_start, rx_flush, tx_flush, ack_send, ack_pending;
  wire logic decrypt_start, encrypt_start, tx_byte_valid, rx_pop;
  wire logic [2:0] radio_state;
  wire logic [1:0] security_mode;
  wire logic [7:0] tx_byte, ram_addr, ram_rdata;
  wire logic [7:0] pulse_v; // All pulse outputs, cal_start on top
  int err_count, checked, cycles;
  int cnt [8]; // Pulse tallies by pulse_v bit
  logic [15:0] txq = 16'h0000; // Last two queued transmit bytes
  // Strobe, channel clear and resulting state
  logic [15:0] rtab [9] = '{16'h0303, 16'h0206, 16'h0303, 16'h0402, 16'h0601,
    16'h0001, 16'h0501, 16'h0512, 16'h0601};
  // Strobe and the pulse it raises
  logic [15:0] ptab [7] = '{16'h0A04, 16'h0806, 16'h0905, 16'h0C03, 16'h0D02,
    16'h0B04, 16'h0207};
  assign pulse_v = {cal_start, rx_flush, tx_flush, ack_send, decrypt_start, encrypt_start,
    tx_byte_valid, rx_pop};
  // RAM contents follow the address
  assign ram_rdata = ram_addr ^ 8'h3C;
  rcsd_top i_dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .csn_n(csn_n), .si(si),
    .cca_clear(cca_clear), .rx_byte(rx_byte), .ram_rdata(ram_rdata), .so(so), .so_oe(so_oe),
    .osc_enable(osc_enable), .bias_enable(bias_enable), .radio_state(radio_state),
    .security_mode(security_mode), .cal_start(cal_start), .rx_flush(rx_flush),
    .tx_flush(tx_flush), .ack_send(ack_send), .ack_pending(ack_pending),
    .decrypt_start(decrypt_start), .encrypt_start(encrypt_start),
    .tx_byte_valid(tx_byte_valid), .tx_byte(tx_byte), .rx_pop(rx_pop), .ram_addr(ram_addr));
  rcsd_host i_host (.sclk(sclk), .csn_n(csn_n), .si(si), .so(so));
  // System clock, 50 ns
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Pulse tallies, byte capture and hang guard
  always @(posedge clk) begin
    for (int k = 0; k < 8; k++) if (pulse_v[k] === 1'b1) cnt[k]++;
    if (tx_byte_valid === 1'b1) txq <= {txq[7:0], tx_byte};
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  // Register test pattern
  function automatic logic [15:0] pat(input logic [5:0] a);
    return {a, 4'hA, a} ^ 16'h5A00;
  endfunction
  // Event spacing, ends just after a clock edge
  task automatic gap();
    repeat (10) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic strobe(input logic [5:0] a, output logic [7:0] st);
    logic [31:0] r;
    i_host.frame({24'h0, 2'b00, a}, 8, r);
    st = r[7:0];
    gap();
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [31:0] r;
    i_host.frame({8'h0, 2'b00, a, d}, 24, r);
    gap();
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    logic [31:0] r;
    i_host.frame({8'h0, 2'b01, a, 16'h0}, 24, r);
    d = r[15:0];
    gap();
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    logic [15:0] d;
    logic [7:0] st;
    logic [31:0] r;
    logic [2:0] prev;
    int b;
    rst_n = 1'b0;
    cca_clear = 1'b0;
    rx_byte = 8'h5A;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    gap();
    rd(rcsd_pkg::REG_FIRST, d);
    check("main", d, rcsd_pkg::MAIN_RESET);
    strobe(rcsd_pkg::STROBE_NO_OPERATION, st);
    check("status", st, rcsd_pkg::STATUS_RESET);
    check("state", radio_state, rcsd_pkg::ST_OFF);
    strobe(rcsd_pkg::STROBE_OSCILLATOR_ON, st);
    check("osc", {osc_enable, bias_enable, radio_state}, 5'h19);
    rd(rcsd_pkg::REG_FIRST, d);
    check("main", d, 16'h8000);
    strobe(rcsd_pkg::STROBE_NO_OPERATION, st);
    check("osc bit", st[rcsd_pkg::ST_OSC_BIT], 1'b1);
    // All ordinary registers above main control, read-only state register left out
    for (int a = 6'h11; a <= 6'h30; a++) if (a != 6'h2C) wr(6'(a), pat(6'(a)));
    for (int a = 6'h11; a <= 6'h30; a++) begin
      if (a != 6'h2C) begin
        rd(6'(a), d);
        check("reg", d, pat(6'(a)));
      end
    end
    d = pat(rcsd_pkg::REG_SECURITY);
    check("sec mode", security_mode, d[1:0]);
    // Soft reset through the control bit
    wr(rcsd_pkg::REG_FIRST, 16'h0000);
    wr(rcsd_pkg::REG_FIRST, 16'h8000);
    rd(rcsd_pkg::REG_FIRST, d);
    check("main kept", d, 16'h8000);
    rd(6'h11, d);
    check("cfg reset", d, rcsd_pkg::CFG_RESET);
    check("sec reset", security_mode, 2'b00);
    // Radio state walk, encryption on since mode is nonzero
    wr(rcsd_pkg::REG_SECURITY, 16'h0001);
    prev = rcsd_pkg::ST_IDLE;
    foreach (rtab[i]) begin
      cca_clear = rtab[i][4];
      b = cnt[2];
      strobe(6'(rtab[i][15:8]), st);
      check("rx bit", st[rcsd_pkg::ST_RX_BIT], prev == rcsd_pkg::ST_RX);
      check("tx bit", st[rcsd_pkg::ST_TX_BIT], prev == rcsd_pkg::ST_TX);
      prev = rtab[i][2:0];
      check("state", radio_state, prev);
      check("encrypt", 16'(cnt[2] - b), 16'(prev == rcsd_pkg::ST_TX));
    end
    // Receive byte taken before any flush
    b = cnt[0];
    i_host.frame({16'h0, 2'b01, rcsd_pkg::ADDR_RX_QUEUE, 8'h00}, 16, r);
    gap();
    check("rx byte", r[7:0], 8'h5A);
    check("pop", 16'(cnt[0] - b), 16'h1);
    foreach (ptab[i]) begin
      b = cnt[ptab[i][2:0]];
      strobe(6'(ptab[i][15:8]), st);
      check("pulse", 16'(cnt[ptab[i][2:0]] - b), 16'h1);
      if (ptab[i][15:8] == 8'h0A) check("pending", ack_pending, 1'b0);
      if (ptab[i][15:8] == 8'h0B) check("pending", ack_pending, 1'b1);
      if (ptab[i][15:8] == 8'h0D) check("no tx", radio_state, rcsd_pkg::ST_IDLE);
    end
    // Two queued transmit bytes, status echoed on each
    b = cnt[1];
    i_host.frame({8'h0, 2'b00, rcsd_pkg::ADDR_TX_QUEUE, 16'h9669}, 24, r);
    gap();
    check("tx bytes", txq, 16'h9669);
    check("tx count", 16'(cnt[1] - b), 16'h2);
    // Oscillator on and calibrated, neither receive nor transmit
    check("status on tx", r[15:0], 16'h5050);
    b = cnt[0];
    i_host.frame({16'h0, 2'b01, rcsd_pkg::ADDR_TX_QUEUE, 8'h00}, 16, r);
    gap();
    check("no pop", 16'(cnt[0] - b), 16'h0);
    // RAM read leaves both queues alone
    b = cnt[0] + cnt[1];
    i_host.frame({8'h0, 8'hC0, 8'h21, 8'h00}, 24, r);
    gap();
    check("ram data", r[7:0], 8'h1D);
    // Address flop lets go once the select rises
    check("ram addr", ram_addr, 8'h00);
    check("ram no pop", 16'(cnt[0] + cnt[1] - b), 16'h0);
    strobe(rcsd_pkg::STROBE_OSCILLATOR_OFF, st);
    check("osc off", {osc_enable, bias_enable, radio_state}, 5'h00);
    strobe(rcsd_pkg::STROBE_RECEIVE_ON, st);
    check("off holds", radio_state, rcsd_pkg::ST_OFF);
    // Whole-word control write, then pin reset mid-run
    wr(rcsd_pkg::REG_FIRST, 16'hC000);
    rd(rcsd_pkg::REG_FIRST, d);
    check("main write", d, 16'hC000);
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    gap();
    rd(rcsd_pkg::REG_FIRST, d);
    check("main pin", d, rcsd_pkg::MAIN_RESET);
    report_and_stop();
  end
endmodule
`default_nettype wire
